// file: bench/spsr_flash_model.sv
/* serial peripheral on the link: counts clock rises while selected,
   and plays a second master asserting contention on command.
   assumes: sampled on clk_sys, link clock much slower. */
`timescale 1ns/1ps
module spsr_flash_model (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        sclk,
    input  wire        sel_n,
    input  wire        contend_req,
    output wire        contention_pin,
    output reg  [15:0] rise_cnt_ff
);
    reg sclk_q_ff;
    ////////////////////////////////////////////////////////////////////
    // rises only count while selected, as a real part only shifts then
    always @(posedge clk_sys) begin
        sclk_q_ff <= sclk;
        if (!rst_n)
            rise_cnt_ff <= 16'h0000;
        else if (!sel_n && sclk && !sclk_q_ff)
            rise_cnt_ff <= rise_cnt_ff + 16'h0001;
    end
    // contention line is driven only when the bench asks
    assign contention_pin = contend_req;
endmodule // spsr_flash_model

// file: bench/spsr_regs_assertions.sv
/* checks on the ports of the register slice.
   assumes: one clock, synchronous active-low reset, bound below. */
`timescale 1ns/1ps
module spsr_regs_chk #(
    parameter DEPTH   = 16,
    parameter NUM_SEL = 1
) (
    input wire               clk_sys,
    input wire               rst_n,
    input wire [7:0]         reg_addr,
    input wire [31:0]        reg_wdata,
    input wire               reg_wr,
    input wire               reg_rd,
    input wire [31:0]        reg_rdata_ff,
    input wire               tx_push,
    input wire               tx_pop,
    input wire               rx_push,
    input wire               rx_pop,
    input wire               port_busy,
    input wire               collision_error,
    input wire               transmission_error,
    input wire               contention_pin,
    input wire [NUM_SEL-1:0] periph_sel_n_ff,
    input wire               sclk_ff,
    input wire [2:0]         three_wire_ctrl_ff,
    input wire               irq_ff,
    input wire               tx_dma_req_ff,
    input wire               rx_dma_req_ff
);
    reg  mask_seen_ff;
    reg  dma_seen_ff;
    wire sel_wr = reg_wr && reg_addr == 8'h10;
    ////////////////////////////////////////////////////////////////////
    // irq and dma requests must stay low until software enables them
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_seen_ff <= 1'b0;
            dma_seen_ff  <= 1'b0;
        end else begin
            mask_seen_ff <= mask_seen_ff | (reg_wr & (reg_addr == 8'h2c));
            dma_seen_ff  <= dma_seen_ff | (reg_wr & (reg_addr == 8'h4c));
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // two reads in a row, no new event of that kind in the first
    sequence clr_pair(a, ev);
        reg_rd && reg_addr == a && !ev ##1 reg_rd && reg_addr == a;
    endsequence
    sequence sel_settle;
        sel_wr ##1 !sel_wr [*2];
    endsequence
    clr_upper_a: assert property (reg_rd && reg_addr >= 8'h38 && reg_addr <= 8'h48
        |=> reg_rdata_ff[31:1] == 31'h0) else $error("clear reg upper bits set");
    tx_clr_a: assert property (clr_pair(8'h38, tx_push) |=> !reg_rdata_ff[0])
        else $error("tx overflow not cleared by read");
    rx_clr_a: assert property (clr_pair(8'h3c, rx_push) |=> !reg_rdata_ff[0])
        else $error("rx overflow not cleared by read");
    sel_drive_a: assert property (sel_settle |-> periph_sel_n_ff[0] == !$past(reg_wdata[0], 2))
        else $error("select pin does not follow register");
    stat_bits_a: assert property (reg_rd && reg_addr == 8'h28 && $stable(port_busy)
        && $stable(collision_error) |=> reg_rdata_ff[0] == $past(port_busy)
        && reg_rdata_ff[6] == $past(collision_error) && reg_rdata_ff[31:7] == 25'h0)
        else $error("status bits wrong");
    irq_quiet_a: assert property (!mask_seen_ff |-> !irq_ff)
        else $error("irq with all masks off");
    dma_quiet_a: assert property (!dma_seen_ff |-> !tx_dma_req_ff && !rx_dma_req_ff)
        else $error("dma request before enable");
    sclk_busy_a: assert property ($rose(sclk_ff) |-> $past(port_busy))
        else $error("serial clock rose while idle");
endmodule // spsr_regs_chk

bind spsr_regs spsr_regs_chk #(.DEPTH(DEPTH), .NUM_SEL(NUM_SEL)) i_chk (.clk_sys, .rst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff, .tx_push, .tx_pop, .rx_push,
    .rx_pop, .port_busy, .collision_error, .transmission_error, .contention_pin,
    .periph_sel_n_ff, .sclk_ff, .three_wire_ctrl_ff, .irq_ff, .tx_dma_req_ff, .rx_dma_req_ff);

// file: bench/test_spsr_regs.sv
/* self-checking bench: register table, then fifo, irq, dma and link cases.
   assumes: slice and map header under hw/, model and checker beside. */
`timescale 1ns/1ps
module test_spsr_regs;
    typedef struct {logic [7:0] a; logic [31:0] e; logic [31:0] r;} spsr_row_t;
    localparam int NROW = 20;
    localparam logic [3:0] TXU = 4'h1, TXO = 4'h2, RXU = 4'h4, RXO = 4'h8;
    logic        clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, port_busy = 0;
    logic        coll = 0, terr = 0, contend = 0, sel_n, sclk, irq, tx_req, rx_req, pin;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, rdata;
    logic [3:0]  fstb = 4'h0;
    logic [2:0]  tw;
    logic [15:0] rises;
    int          bad_count = 0, compares = 0, cycles = 0;
    // address, readback after all-ones write, reset value
    spsr_row_t rows [NROW] = '{'{8'h0c, 32'h7, 0}, '{8'h10, 32'h1, 0}, '{8'h14, 32'hffff, 0},
        '{8'h18, 32'hff, 0}, '{8'h1c, 32'hff, 0}, '{8'h20, 0, 0}, '{8'h24, 0, 0},
        '{8'h28, 32'h6, 32'h6}, '{8'h2c, 32'h3f, 0}, '{8'h30, 32'h1, 0}, '{8'h34, 1, 1},
        '{8'h38, 0, 0}, '{8'h3c, 0, 0}, '{8'h40, 0, 0}, '{8'h44, 0, 0}, '{8'h48, 0, 0},
        '{8'h4c, 32'h3, 0}, '{8'h50, 32'hff, 0}, '{8'h54, 32'hff, 0}, '{8'hfc, 0, 0}};
    always #50 clk_sys = ~clk_sys;
    spsr_regs #(.DEPTH(16), .NUM_SEL(1)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_ff(rdata), .tx_push(fstb[0]), .tx_pop(fstb[1]), .rx_push(fstb[2]),
        .rx_pop(fstb[3]), .port_busy(port_busy), .collision_error(coll),
        .transmission_error(terr), .contention_pin(pin), .periph_sel_n_ff(sel_n),
        .sclk_ff(sclk), .three_wire_ctrl_ff(tw), .irq_ff(irq), .tx_dma_req_ff(tx_req),
        .rx_dma_req_ff(rx_req));
    spsr_flash_model i_far (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .sel_n(sel_n),
        .contend_req(contend), .contention_pin(pin), .rise_cnt_ff(rises));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // optional second read back to back, to see the clear take effect
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] e2 = 0,
        input logic two = 0);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= two;
        #1 chk($sformatf("reg %h", a), e, rdata);
        if (two) begin
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1 chk($sformatf("reg %h again", a), e2, rdata);
        end
    endtask
    task automatic fifo(input logic [3:0] s, input int n);
        repeat (n) @(posedge clk_sys) fstb <= s;
        @(posedge clk_sys) fstb <= 4'h0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    task automatic finish_test;
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard, several times the under-a-thousand cycles the run needs
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("sel_n", 1, {31'h0, sel_n});
        for (int i = 0; i < NROW; i++)
            rd(rows[i].a, rows[i].r);
        for (int i = 0; i < NROW; i++) begin
            wr(rows[i].a, 32'hffff_ffff);
            rd(rows[i].a, rows[i].e);
        end
        chk("outs", 32'h7c, {25'h0, tw, irq, tx_req, rx_req, sel_n});
        @(posedge clk_sys) rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys) rst_n <= 1'b1;
        // tx overflow: one push past a full fifo, then clear by read
        fifo(TXU, 17);
        rd(8'h20, 32'h10);
        rd(8'h28, 32'h0);
        rd(8'h34, 32'h2);
        wr(8'h2c, 32'h2);
        fifo(0, 0);
        chk("irq", 1, {31'h0, irq});
        rd(8'h30, 32'h2);
        rd(8'h38, 32'h1, 32'h0, 1);
        fifo(TXO, 16);
        chk("irq", 0, {31'h0, irq});
        // rx side: underflow, watermark plus one, overflow
        wr(8'h54, 32'h1);
        wr(8'h4c, 32'h1);
        fifo(RXO, 1);
        fifo(RXU, 1);
        chk("rx_req", 0, {31'h0, rx_req});
        fifo(RXU, 1);
        chk("rx_req", 1, {31'h0, rx_req});
        fifo(RXU, 15);
        rd(8'h28, 32'h1e);
        rd(8'h34, 32'h1d);
        rd(8'h3c, 32'h1, 32'h0, 1);
        rd(8'h40, 32'h1, 32'h0, 1);
        wr(8'h1c, 32'h10);
        rd(8'h34, 32'h1);
        fifo(RXO, 16);
        wr(8'h4c, 32'h3);
        fifo(0, 0);
        chk("tx_req", 1, {31'h0, tx_req});
        fifo(TXU, 1);
        chk("tx_req", 0, {31'h0, tx_req});
        fifo(TXO, 1);
        // contention from the far side, then both clear registers
        @(posedge clk_sys) contend <= 1'b1;
        repeat (6) @(posedge clk_sys) contend <= 1'b0;
        fifo(RXO, 1);
        rd(8'h34, 32'h25);
        rd(8'h44, 32'h1);
        rd(8'h48, 32'h1, 32'h0, 1);
        fifo(RXO, 1);
        wr(8'h80, 32'h4);
        rd(8'h34, 32'h1);
        // link clock: divide by eight (800 ns) for forty busy cycles, five rises
        wr(8'h14, 32'h8);
        wr(8'h10, 32'h1);
        @(posedge clk_sys) {port_busy, coll, terr} <= 3'h7;
        rd(8'h28, 32'h67);
        repeat (38) @(posedge clk_sys);
        {port_busy, coll, terr} <= 3'h0;
        fifo(0, 2);
        chk("rises", 32'd5, {16'h0, rises});
        chk("sclk", 0, {31'h0, sclk});
        wr(8'h10, 32'h0);
        fifo(0, 0);
        chk("sel_n", 1, {31'h0, sel_n});
        finish_test();
    end
endmodule // test_spsr_regs

// file: hw/spsr_map.vh
/*
 * register map, field positions and reset values of the serial port
 * status and interrupt register slice.
 * assumes: included by the slice itself; byte addresses, word aligned.
 */
`ifndef SPSR_MAP_VH
`define SPSR_MAP_VH

// register byte addresses
`define SPSR_A_3WIRE    8'h0c
`define SPSR_A_SEL      8'h10
`define SPSR_A_DIV      8'h14
`define SPSR_A_TXTHR    8'h18
`define SPSR_A_RXTHR    8'h1c
`define SPSR_A_TXLVL    8'h20
`define SPSR_A_RXLVL    8'h24
`define SPSR_A_STAT     8'h28
`define SPSR_A_MASK     8'h2c
`define SPSR_A_MSTAT    8'h30
`define SPSR_A_RAW      8'h34
`define SPSR_A_TXOCLR   8'h38
`define SPSR_A_RXOCLR   8'h3c
`define SPSR_A_RXUCLR   8'h40
`define SPSR_A_CONCLR   8'h44
`define SPSR_A_ALLCLR   8'h48
`define SPSR_A_DMA      8'h4c
`define SPSR_A_TXDMA    8'h50
`define SPSR_A_RXDMA    8'h54
`define SPSR_A_WCLR     8'h80

// interrupt bit positions, shared by mask, raw and masked status
`define SPSR_I_TXEMP    0
`define SPSR_I_TXO      1
`define SPSR_I_RXU      2
`define SPSR_I_RXO      3
`define SPSR_I_RXF      4
`define SPSR_I_CON      5

// dma control bits
`define SPSR_D_RX       0
`define SPSR_D_TX       1

// reset values and small constants
`define SPSR_R_ZERO32   32'h0000_0000
`define SPSR_R_ZERO16   16'h0000
`define SPSR_R_ZERO8    8'h00
`define SPSR_R_ZERO6    6'h00
`define SPSR_R_ZERO3    3'h0
`define SPSR_R_ZERO2    2'h0
`define SPSR_ONE8       8'h01
`define SPSR_ONE9       9'h001
`define SPSR_ONE16      16'h0001

`endif

// file: hw/spsr_regs.v
/*
 * register slice of a synchronous serial port: three-wire control,
 * peripheral select, clock divider, fifo thresholds and levels, status,
 * interrupt mask/raw/masked status, read-to-clear registers and dma
 * watermarks, with one level interrupt and the divided serial clock.
 * assumes: fifo push/pop strobes, busy and error flags come from logic
 * on clk_sys; the contention input comes from a pin and is synchronised.
 */
`timescale 1ns/1ps
`include "spsr_map.vh"

module spsr_regs #(
    parameter DEPTH   = 16,
    parameter NUM_SEL = 1
) (
    input  wire               clk_sys,
    input  wire               rst_n,
    input  wire [7:0]         reg_addr,
    input  wire [31:0]        reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [31:0]        reg_rdata_ff,
    input  wire               tx_push,
    input  wire               tx_pop,
    input  wire               rx_push,
    input  wire               rx_pop,
    input  wire               port_busy,
    input  wire               collision_error,
    input  wire               transmission_error,
    input  wire               contention_pin,
    output reg  [NUM_SEL-1:0] periph_sel_n_ff,
    output reg                sclk_ff,
    output reg  [2:0]         three_wire_ctrl_ff,
    output reg                irq_ff,
    output reg                tx_dma_req_ff,
    output reg                rx_dma_req_ff
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // strobe aimed at one register; every side effect keys off this, so a
    // write clears a read-to-clear flag only through the write-clear register and a read never writes
    function bus_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            bus_hit = strobe && (addr == target);
        end
    endfunction

    // fifo level at capacity; a push here is lost and flags overflow
    function lvl_full;
        input [7:0] lvl;
        begin
            lvl_full = (lvl >= DEPTH[7:0]);
        end
    endfunction

    // fifo level at zero; a pop here is lost, and on the rx fifo flags underflow
    function lvl_empty;
        input [7:0] lvl;
        begin
            lvl_empty = (lvl == `SPSR_R_ZERO8);
        end
    endfunction

    // next fill level; pushes past full and pops from empty are dropped
    function [7:0] nxt_level;
        input [7:0] lvl;
        input       push;
        input       pop;
        reg         do_push;
        reg         do_pop;
        begin
            do_push = push && !lvl_full(lvl);
            do_pop  = pop && !lvl_empty(lvl);
            if (do_push && !do_pop)
                nxt_level = lvl + `SPSR_ONE8;
            else if (do_pop && !do_push)
                nxt_level = lvl - `SPSR_ONE8;
            else
                nxt_level = lvl;
        end
    endfunction

    // sticky flag: a set in the clearing cycle wins
    function sticky;
        input cur;
        input set;
        input clr;
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // state

    // software copies, fifo levels, sticky flags, divider and synchroniser
    reg [2:0]         three_wire_ff;
    reg [NUM_SEL-1:0] sel_ff;
    reg [15:0]        div_ff;
    reg [7:0]         tx_thr_ff;
    reg [7:0]         rx_thr_ff;
    reg [7:0]         tx_lvl_ff;
    reg [7:0]         rx_lvl_ff;
    reg [5:0]         mask_ff;
    reg               tx_over_ff;
    reg               rx_over_ff;
    reg               rx_under_ff;
    reg               contention_ff;
    reg [1:0]         dma_en_ff;
    reg [7:0]         tx_dma_lvl_ff;
    reg [7:0]         rx_dma_lvl_ff;
    reg [15:0]        div_cnt_ff;
    reg               con_meta_ff;
    reg               con_sync_ff;

    // whole-register decodes shared by several clear strobes
    wire wr_hit_wclr = bus_hit(reg_wr, reg_addr, `SPSR_A_WCLR);
    wire rd_allclr   = bus_hit(reg_rd, reg_addr, `SPSR_A_ALLCLR);

    // clear strobes: own register, combined register, or write clear
    wire clr_txo = bus_hit(reg_rd, reg_addr, `SPSR_A_TXOCLR) || rd_allclr
                   || (wr_hit_wclr && reg_wdata[`SPSR_I_TXO]);
    wire clr_rxo = bus_hit(reg_rd, reg_addr, `SPSR_A_RXOCLR) || rd_allclr
                   || (wr_hit_wclr && reg_wdata[`SPSR_I_RXO]);
    wire clr_rxu = bus_hit(reg_rd, reg_addr, `SPSR_A_RXUCLR) || rd_allclr
                   || (wr_hit_wclr && reg_wdata[`SPSR_I_RXU]);
    wire clr_con = bus_hit(reg_rd, reg_addr, `SPSR_A_CONCLR) || rd_allclr
                   || (wr_hit_wclr && reg_wdata[`SPSR_I_CON]);

    // overflow and underflow events seen at the fifo ports
    wire set_txo = tx_push && lvl_full(tx_lvl_ff);
    wire set_rxo = rx_push && lvl_full(rx_lvl_ff);
    wire set_rxu = rx_pop && lvl_empty(rx_lvl_ff);

    // level conditions: tx at or below threshold, rx above threshold
    wire tx_empty_raw = (tx_lvl_ff <= tx_thr_ff);
    wire rx_full_raw  = (rx_lvl_ff > rx_thr_ff);

    // raw status: two live levels beside the four sticky flags
    wire [5:0] raw_stat;
    assign raw_stat[`SPSR_I_TXEMP] = tx_empty_raw;
    assign raw_stat[`SPSR_I_TXO] = tx_over_ff;
    assign raw_stat[`SPSR_I_RXU] = rx_under_ff;
    assign raw_stat[`SPSR_I_RXO] = rx_over_ff;
    assign raw_stat[`SPSR_I_RXF] = rx_full_raw;
    assign raw_stat[`SPSR_I_CON] = contention_ff;

    // masked status feeds both the read mux and the irq flop
    wire [5:0] masked_stat = raw_stat & mask_ff;

    // any sticky flag pending; what the combined clear reads back
    wire any_sticky = tx_over_ff | rx_over_ff | rx_under_ff | contention_ff;

    // status word, bits 6..0; full and empty use the same tests that
    // guard the level counters, so status never disagrees with them
    wire [6:0] port_stat = {collision_error,
                            transmission_error,
                            lvl_full(rx_lvl_ff),
                            !lvl_empty(rx_lvl_ff),
                            lvl_empty(tx_lvl_ff),
                            !lvl_full(tx_lvl_ff),
                            port_busy};

    ////////////////////////////////////////////////////////////////////
    // contention pin synchroniser, first stage read only by the second

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            con_meta_ff <= 1'b0;
            con_sync_ff <= 1'b0;
        end else begin
            con_meta_ff <= contention_pin;
            con_sync_ff <= con_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software writable registers

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            three_wire_ff <= `SPSR_R_ZERO3;
            sel_ff        <= {NUM_SEL{1'b0}};
            div_ff        <= `SPSR_R_ZERO16;
            tx_thr_ff     <= `SPSR_R_ZERO8;
            rx_thr_ff     <= `SPSR_R_ZERO8;
            mask_ff       <= `SPSR_R_ZERO6;
            dma_en_ff     <= `SPSR_R_ZERO2;
            tx_dma_lvl_ff <= `SPSR_R_ZERO8;
            rx_dma_lvl_ff <= `SPSR_R_ZERO8;
        end else if (reg_wr) begin
            case (reg_addr)
                `SPSR_A_3WIRE: three_wire_ff <= reg_wdata[2:0];
                `SPSR_A_SEL:   sel_ff        <= reg_wdata[NUM_SEL-1:0];
                `SPSR_A_DIV:   div_ff        <= reg_wdata[15:0];
                `SPSR_A_TXTHR: tx_thr_ff     <= reg_wdata[7:0];
                `SPSR_A_RXTHR: rx_thr_ff     <= reg_wdata[7:0];
                `SPSR_A_MASK:  mask_ff       <= reg_wdata[5:0];
                `SPSR_A_DMA:   dma_en_ff     <= reg_wdata[1:0];
                `SPSR_A_TXDMA: tx_dma_lvl_ff <= reg_wdata[7:0];
                `SPSR_A_RXDMA: rx_dma_lvl_ff <= reg_wdata[7:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // fifo levels and sticky interrupt flags
    // a set in the same cycle as its clear wins, so no event is lost

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_lvl_ff     <= `SPSR_R_ZERO8;
            rx_lvl_ff     <= `SPSR_R_ZERO8;
            tx_over_ff    <= 1'b0;
            rx_over_ff    <= 1'b0;
            rx_under_ff   <= 1'b0;
            contention_ff <= 1'b0;
        end else begin
            tx_lvl_ff     <= nxt_level(tx_lvl_ff, tx_push, tx_pop);
            rx_lvl_ff     <= nxt_level(rx_lvl_ff, rx_push, rx_pop);
            tx_over_ff    <= sticky(tx_over_ff, set_txo, clr_txo);
            rx_over_ff    <= sticky(rx_over_ff, set_rxo, clr_rxo);
            rx_under_ff   <= sticky(rx_under_ff, set_rxu, clr_rxu);
            contention_ff <= sticky(contention_ff, con_sync_ff, clr_con);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; data appear the cycle after the strobe, unmapped reads 0
    // clear registers return the flag as it stood before the clear

    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = `SPSR_R_ZERO32;
        case (reg_addr)
            `SPSR_A_3WIRE:  nxt_rdata[2:0]  = three_wire_ff;
            `SPSR_A_SEL:    nxt_rdata[NUM_SEL-1:0] = sel_ff;
            `SPSR_A_DIV:    nxt_rdata[15:0] = div_ff;
            `SPSR_A_TXTHR:  nxt_rdata[7:0]  = tx_thr_ff;
            `SPSR_A_RXTHR:  nxt_rdata[7:0]  = rx_thr_ff;
            `SPSR_A_TXLVL:  nxt_rdata[7:0]  = tx_lvl_ff;
            `SPSR_A_RXLVL:  nxt_rdata[7:0]  = rx_lvl_ff;
            `SPSR_A_STAT:   nxt_rdata[6:0]  = port_stat;
            `SPSR_A_MASK:   nxt_rdata[5:0]  = mask_ff;
            `SPSR_A_MSTAT:  nxt_rdata[5:0]  = masked_stat;
            `SPSR_A_RAW:    nxt_rdata[5:0]  = raw_stat;
            `SPSR_A_TXOCLR: nxt_rdata[0]    = tx_over_ff;
            `SPSR_A_RXOCLR: nxt_rdata[0]    = rx_over_ff;
            `SPSR_A_RXUCLR: nxt_rdata[0]    = rx_under_ff;
            `SPSR_A_CONCLR: nxt_rdata[0]    = contention_ff;
            `SPSR_A_ALLCLR: nxt_rdata[0]    = any_sticky;
            `SPSR_A_DMA:    nxt_rdata[1:0]  = dma_en_ff;
            `SPSR_A_TXDMA:  nxt_rdata[7:0]  = tx_dma_lvl_ff;
            `SPSR_A_RXDMA:  nxt_rdata[7:0]  = rx_dma_lvl_ff;
            default:        nxt_rdata       = `SPSR_R_ZERO32;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (!rst_n)
            reg_rdata_ff <= `SPSR_R_ZERO32;
        else if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
        else
            reg_rdata_ff <= `SPSR_R_ZERO32;
    end

    ////////////////////////////////////////////////////////////////////
    // serial clock divider: toggles every div/2 cycles while busy;
    // divisor 0 or 1 holds the clock low since no faster edge exists;
    // odd divisors round down to the even one below, one counter only

    wire [15:0] half_div = {1'b0, div_ff[15:1]};
    wire        div_run  = port_busy && (half_div != `SPSR_R_ZERO16);

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            div_cnt_ff <= `SPSR_R_ZERO16;
            sclk_ff    <= 1'b0;
        end else if (!div_run) begin
            div_cnt_ff <= `SPSR_R_ZERO16;
            sclk_ff    <= 1'b0;
        end else if (div_cnt_ff >= half_div - `SPSR_ONE16) begin
            div_cnt_ff <= `SPSR_R_ZERO16;
            sclk_ff    <= ~sclk_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + `SPSR_ONE16;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs: select, three-wire control, irq, dma requests
    // select is active low at the pin, so a 0 bit leaves it high

    // rx request uses watermark plus one, widened to avoid wrap at 0xff
    wire [8:0] rx_dma_thr = {1'b0, rx_dma_lvl_ff} + `SPSR_ONE9;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            periph_sel_n_ff    <= {NUM_SEL{1'b1}};
            three_wire_ctrl_ff <= `SPSR_R_ZERO3;
            irq_ff             <= 1'b0;
            tx_dma_req_ff      <= 1'b0;
            rx_dma_req_ff      <= 1'b0;
        end else begin
            periph_sel_n_ff    <= ~sel_ff;
            three_wire_ctrl_ff <= three_wire_ff;
            irq_ff             <= |masked_stat;
            tx_dma_req_ff      <= dma_en_ff[`SPSR_D_TX]
                                  && (tx_lvl_ff <= tx_dma_lvl_ff);
            rx_dma_req_ff      <= dma_en_ff[`SPSR_D_RX]
                                  && ({1'b0, rx_lvl_ff} >= rx_dma_thr);
        end
    end

endmodule // spsr_regs
